// >>> inc/irq_pkg.sv
// constants of the interrupt request controller: register indices, field positions, reset values
package irq_pkg;
	// register bus
	localparam int ADDR_W = 6;
	localparam int IDX_W = 4;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// register indices, byte address is four times the index
	localparam logic [3:0] IDX_FLAGS_A = 4'h6;
	localparam logic [3:0] IDX_FLAGS_B = 4'h7;
	localparam logic [3:0] IDX_ENABLE_A = 4'h8;
	localparam logic [3:0] IDX_ENABLE_B = 4'h9;
	localparam logic [3:0] IDX_ERROR = 4'hA;
	localparam logic [3:0] IDX_EVT_STATUS = 4'hC;
	localparam logic [3:0] IDX_EVT_MASK = 4'hD;
	// request flag registers
	localparam int MODE_BIT = 7;
	localparam int GLOBAL_BIT = 6;
	localparam int CARD_BIT = 5;
	localparam int HIGH_ALERT_BIT = 6;
	localparam int LOW_ALERT_BIT = 5;
	localparam int CMD_DONE_BIT = 4;
	localparam int TX_DONE_BIT = 3;
	localparam int RX_DONE_BIT = 2;
	localparam int ERROR_BIT = 1;
	localparam int FRAME_START_BIT = 0;
	// enable registers
	localparam int POLARITY_BIT = 7;
	localparam int PUSH_PULL_BIT = 7;
	localparam int PIN_ENABLE_BIT = 6;
	// error bits that raise the error request flag
	localparam logic [7:0] ERR_TRIGGER_MASK = 8'h6B;
	// event status bits
	localparam int EVT_W = 3;
	localparam int EVT_GLOBAL = 0;
	localparam int EVT_ERROR = 1;
	localparam int EVT_CARD = 2;
	// reset values
	localparam logic [6:0] FLAGS_A_RST = 7'h00;
	localparam logic [5:0] FLAGS_B_RST = 6'h00;
	localparam logic [7:0] ENABLE_RST = 8'h00;
	localparam logic [7:0] ERROR_RST = 8'h00;
	localparam logic [2:0] EVT_RST = 3'h0;
endpackage

// >>> inc/regbus_if.sv
// register access strobes between the bus slave and the register file
`timescale 1ns/1ps
interface regbus_if;
	logic wr_en;
	logic [3:0] wr_idx;
	logic [7:0] wr_data;
	logic wr_err;
	logic rd_en;
	logic [3:0] rd_idx;
	logic [7:0] rd_data;
	logic rd_err;
	modport bus (output wr_en, wr_idx, wr_data, rd_en, rd_idx, input wr_err, rd_data, rd_err);
	modport regs (input wr_en, wr_idx, wr_data, rd_en, rd_idx, output wr_err, rd_data, rd_err);
endinterface

// >>> core/axil_slave.sv
// AXI4-Lite slave that turns bus transfers into register strobes
`timescale 1ns/1ps
module axil_slave
	import irq_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// write channels
	input wire logic [irq_pkg::ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// read channels
	input wire logic [irq_pkg::ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// register side
	regbus_if.bus rb
);
	import irq_pkg::*;

	logic aw_held;
	logic w_held;
	logic lane_on;
	logic [3:0] aw_idx;
	logic [7:0] w_byte;
	logic do_wr;

	assign do_wr = aw_held && w_held && !bvalid;
	// only byte lane 0 carries register data
	assign rb.wr_en = do_wr && lane_on;
	assign rb.wr_idx = aw_idx;
	assign rb.wr_data = w_byte;
	assign rb.rd_en = arready && arvalid;
	assign rb.rd_idx = araddr[5:2];

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			awready <= 1'b0;
			aw_held <= 1'b0;
			aw_idx <= 4'h0;
		end else if (awready && awvalid) begin
			awready <= 1'b0;
			aw_held <= 1'b1;
			aw_idx <= awaddr[5:2];
		end else if (do_wr) begin
			aw_held <= 1'b0;
		end else if (!aw_held && !bvalid) begin
			awready <= 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wready <= 1'b0;
			w_held <= 1'b0;
			w_byte <= 8'h00;
			lane_on <= 1'b0;
		end else if (wready && wvalid) begin
			wready <= 1'b0;
			w_held <= 1'b1;
			w_byte <= wdata[7:0];
			lane_on <= wstrb[0];
		end else if (do_wr) begin
			w_held <= 1'b0;
		end else if (!w_held && !bvalid) begin
			wready <= 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
		end else if (do_wr) begin
			bvalid <= 1'b1;
			bresp <= rb.wr_err ? RESP_SLVERR : RESP_OKAY;
		end else if (bvalid && bready) begin
			bvalid <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			arready <= 1'b0;
			rvalid <= 1'b0;
			rdata <= 32'h0000_0000;
			rresp <= RESP_OKAY;
		end else if (arready && arvalid) begin
			arready <= 1'b0;
			rvalid <= 1'b1;
			rdata <= {24'h00_0000, rb.rd_data};
			rresp <= rb.rd_err ? RESP_SLVERR : RESP_OKAY;
		end else if (rvalid && rready) begin
			rvalid <= 1'b0;
		end else if (!rvalid) begin
			arready <= 1'b1;
		end
	end
endmodule

// >>> core/interrupt_request_controller.sv
// interrupt request flags, enables, error status and interrupt pin control
`timescale 1ns/1ps
module interrupt_request_controller
	import irq_pkg::*;
(
	// clock and reset
	input wire logic CORE_CLK,
	input wire logic RSTN,
	// register bus write channels
	input wire logic [irq_pkg::ADDR_W-1:0] AWADDR,
	input wire logic AWVALID,
	output logic AWREADY,
	input wire logic [31:0] WDATA,
	input wire logic [3:0] WSTRB,
	input wire logic WVALID,
	output logic WREADY,
	output logic [1:0] BRESP,
	output logic BVALID,
	input wire logic BREADY,
	// register bus read channels
	input wire logic [irq_pkg::ADDR_W-1:0] ARADDR,
	input wire logic ARVALID,
	output logic ARREADY,
	output logic [31:0] RDATA,
	output logic [1:0] RRESP,
	output logic RVALID,
	input wire logic RREADY,
	// request events from the reader core
	input wire logic HIGH_ALERT,
	input wire logic LOW_ALERT,
	input wire logic CMD_DONE,
	input wire logic TX_DONE,
	input wire logic RX_DONE,
	input wire logic FRAME_START,
	input wire logic CARD_DETECT,
	input wire logic [4:0] TIMER_UNDERFLOW,
	input wire logic [7:0] ERROR_BITS,
	// interrupt pin and interrupt line
	output logic IRQ_PIN_OUT,
	output logic IRQ_PIN_OE,
	output logic IRQ_LEVEL
);
	import irq_pkg::*;

	regbus_if rb();

	logic [6:0] request_flags_a;
	logic [5:0] request_flags_b;
	logic global_request;
	logic [7:0] request_enable_a;
	logic [7:0] request_enable_b;
	logic [7:0] error_status;
	logic [EVT_W-1:0] evt_status;
	logic [EVT_W-1:0] evt_mask;
	logic [6:0] next_flags_a;
	logic [5:0] next_flags_b;
	logic next_global;
	logic [6:0] hw_set_a;
	logic [5:0] hw_set_b;
	logic [EVT_W-1:0] evt_in;
	logic err_trigger;
	logic wr_a;
	logic wr_b;
	logic set_mode;
	logic pin_active;
	logic pin_level;
	logic [5:0] wr_low_b;
	logic [6:0] wr_low_a;

	axil_slave u_slave (
		.clk(CORE_CLK),
		.rst_n(RSTN),
		.awaddr(AWADDR),
		.awvalid(AWVALID),
		.awready(AWREADY),
		.wdata(WDATA),
		.wstrb(WSTRB),
		.wvalid(WVALID),
		.wready(WREADY),
		.bresp(BRESP),
		.bvalid(BVALID),
		.bready(BREADY),
		.araddr(ARADDR),
		.arvalid(ARVALID),
		.arready(ARREADY),
		.rdata(RDATA),
		.rresp(RRESP),
		.rvalid(RVALID),
		.rready(RREADY),
		.rb(rb)
	);

	// write decode
	assign wr_a = rb.wr_en && (rb.wr_idx == IDX_FLAGS_A);
	assign wr_b = rb.wr_en && (rb.wr_idx == IDX_FLAGS_B);
	assign set_mode = rb.wr_data[MODE_BIT];
	assign wr_low_a = rb.wr_data[6:0];
	assign wr_low_b = rb.wr_data[5:0];

	// hardware sources of the request flags
	assign err_trigger = |(ERROR_BITS & ERR_TRIGGER_MASK);
	assign hw_set_a = {HIGH_ALERT, LOW_ALERT, CMD_DONE, TX_DONE, RX_DONE, err_trigger, FRAME_START};
	assign hw_set_b = {CARD_DETECT, TIMER_UNDERFLOW};

	// a write acts on the ones written; a hardware event in the same cycle wins over a clear
	always_comb begin
		next_flags_a = request_flags_a;
		if (wr_a) begin
			if (set_mode) begin
				next_flags_a = request_flags_a | wr_low_a;
			end else begin
				next_flags_a = request_flags_a & ~wr_low_a;
			end
		end
		next_flags_a = next_flags_a | hw_set_a;
	end

	always_comb begin
		next_flags_b = request_flags_b;
		if (wr_b) begin
			if (set_mode) begin
				next_flags_b = request_flags_b | wr_low_b;
			end else begin
				next_flags_b = request_flags_b & ~wr_low_b;
			end
		end
		next_flags_b = next_flags_b | hw_set_b;
	end

	// gate every flag with its enable into the global request
	assign next_global = |(request_flags_a & request_enable_a[6:0])
		| |(request_flags_b & request_enable_b[5:0]);

	always_ff @(posedge CORE_CLK) begin
		if (!RSTN) begin
			request_flags_a <= FLAGS_A_RST;
		end else begin
			request_flags_a <= next_flags_a;
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (!RSTN) begin
			request_flags_b <= FLAGS_B_RST;
			global_request <= 1'b0;
		end else begin
			request_flags_b <= next_flags_b;
			global_request <= next_global;
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (!RSTN) begin
			request_enable_a <= ENABLE_RST;
			request_enable_b <= ENABLE_RST;
		end else if (rb.wr_en) begin
			if (rb.wr_idx == IDX_ENABLE_A) begin
				request_enable_a <= rb.wr_data;
			end
			if (rb.wr_idx == IDX_ENABLE_B) begin
				request_enable_b <= rb.wr_data;
			end
		end
	end

	// error conditions are produced elsewhere and shown as they stand
	always_ff @(posedge CORE_CLK) begin
		if (!RSTN) begin
			error_status <= ERROR_RST;
		end else begin
			error_status <= ERROR_BITS;
		end
	end

	// interrupt pin: gate, polarity, then drive style
	assign pin_active = global_request && request_enable_b[PIN_ENABLE_BIT];
	assign pin_level = pin_active ^ request_enable_a[POLARITY_BIT];

	always_ff @(posedge CORE_CLK) begin
		if (!RSTN) begin
			IRQ_PIN_OUT <= 1'b0;
			IRQ_PIN_OE <= 1'b1;
		end else if (request_enable_b[PUSH_PULL_BIT]) begin
			IRQ_PIN_OUT <= pin_level;
			IRQ_PIN_OE <= 1'b1;
		end else begin
			// open drain only pulls low, a high level is left to the pull-up
			IRQ_PIN_OUT <= 1'b0;
			IRQ_PIN_OE <= !pin_level;
		end
	end

	// sticky events for the system interrupt line
	assign evt_in[EVT_GLOBAL] = next_global && !global_request;
	assign evt_in[EVT_ERROR] = err_trigger && !request_flags_a[ERROR_BIT];
	assign evt_in[EVT_CARD] = CARD_DETECT && !request_flags_b[CARD_BIT];

	always_ff @(posedge CORE_CLK) begin
		if (!RSTN) begin
			evt_status <= EVT_RST;
		end else if (rb.wr_en && rb.wr_idx == IDX_EVT_STATUS) begin
			evt_status <= (evt_status & ~rb.wr_data[EVT_W-1:0]) | evt_in;
		end else begin
			evt_status <= evt_status | evt_in;
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (!RSTN) begin
			evt_mask <= EVT_RST;
		end else if (rb.wr_en && rb.wr_idx == IDX_EVT_MASK) begin
			evt_mask <= rb.wr_data[EVT_W-1:0];
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (!RSTN) begin
			IRQ_LEVEL <= 1'b0;
		end else begin
			IRQ_LEVEL <= |(evt_status & evt_mask);
		end
	end

	// write answer: any mapped index is accepted, read-only ones ignore the data
	always_comb begin
		unique case (rb.wr_idx)
			IDX_FLAGS_A, IDX_FLAGS_B, IDX_ENABLE_A, IDX_ENABLE_B,
			IDX_ERROR, IDX_EVT_STATUS, IDX_EVT_MASK: rb.wr_err = 1'b0;
			default: rb.wr_err = 1'b1;
		endcase
	end

	// read mux
	always_comb begin
		rb.rd_data = 8'h00;
		rb.rd_err = 1'b0;
		unique case (rb.rd_idx)
			IDX_FLAGS_A: rb.rd_data = {1'b0, request_flags_a};
			IDX_FLAGS_B: rb.rd_data = {1'b0, global_request, request_flags_b};
			IDX_ENABLE_A: rb.rd_data = request_enable_a;
			IDX_ENABLE_B: rb.rd_data = request_enable_b;
			IDX_ERROR: rb.rd_data = error_status;
			IDX_EVT_STATUS: rb.rd_data = {5'h00, evt_status};
			IDX_EVT_MASK: rb.rd_data = {5'h00, evt_mask};
			default: rb.rd_err = 1'b1;
		endcase
	end

	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!RSTN);

	sequence alert_caught;
		HIGH_ALERT ##1 (!HIGH_ALERT && !(wr_a && !set_mode && rb.wr_data[HIGH_ALERT_BIT]));
	endsequence

	sequence tx_standing;
		request_flags_a[TX_DONE_BIT] && !(wr_a && !set_mode && rb.wr_data[TX_DONE_BIT]);
	endsequence

	chk_set_write_b: assert property (
		wr_b && set_mode |=> (request_flags_b & $past(wr_low_b)) == $past(wr_low_b))
		else $error("set-mode write left a flag of the second group clear");

	chk_clear_write_b: assert property (
		wr_b && !set_mode && !CARD_DETECT && TIMER_UNDERFLOW == 5'h00
		|=> (request_flags_b & $past(wr_low_b)) == 6'h00)
		else $error("clear-mode write left a flag of the second group set");

	chk_global_gate: assert property (
		next_global |=> global_request ##1 (IRQ_PIN_OE == ($past(request_enable_b[PUSH_PULL_BIT]) || !$past(pin_level))))
		else $error("global request or pin drive did not follow the enabled flags");

	chk_card_flag: assert property (
		CARD_DETECT |=> request_flags_b[CARD_BIT] && $past(request_flags_b[CARD_BIT]) == !$past(evt_in[EVT_CARD]))
		else $error("card detection did not set its flag");

	chk_timer_flags: assert property (
		TIMER_UNDERFLOW != 5'h00 |=> (request_flags_b[4:0] & $past(TIMER_UNDERFLOW)) == $past(TIMER_UNDERFLOW))
		else $error("timer underflow did not set its flag");

	chk_pin_invert: assert property (
		request_enable_a[POLARITY_BIT] && request_enable_b[PUSH_PULL_BIT] && !pin_active |=> IRQ_PIN_OUT)
		else $error("inverted idle pin not driven high");

	chk_pin_gate: assert property (
		!request_enable_b[PIN_ENABLE_BIT] && !request_enable_a[POLARITY_BIT] |=> !IRQ_PIN_OUT)
		else $error("pin active while the pin enable is off");

	chk_open_drain: assert property (
		!request_enable_b[PUSH_PULL_BIT] |=> !IRQ_PIN_OUT)
		else $error("open drain pin drove a high level");

	chk_set_write_a: assert property (
		wr_a && set_mode |=> (request_flags_a & $past(wr_low_a)) == $past(wr_low_a))
		else $error("set-mode write left a flag of the first group clear");

	chk_error_flag: assert property (
		err_trigger |=> request_flags_a[ERROR_BIT])
		else $error("error condition did not set the error flag");

	chk_tx_sticky: assert property (
		tx_standing |=> request_flags_a[TX_DONE_BIT])
		else $error("transmit flag dropped without a clear write");

	chk_alert_hold: assert property (
		alert_caught |=> request_flags_a[HIGH_ALERT_BIT])
		else $error("high alert flag lost after the alert went away");

	chk_enable_reset: assert property (
		$rose(RSTN) |-> request_enable_a == 8'h00 && request_enable_b == 8'h00 && !IRQ_PIN_OUT)
		else $error("enables not zero after reset");

	chk_event_line: assert property (
		(evt_status & evt_mask) != 3'h0 |=> IRQ_LEVEL)
		else $error("unmasked event did not raise the interrupt line");
endmodule

// >>> dv/irq_host_model.sv
// host microcontroller model that watches the interrupt pin of the device
`timescale 1ns/1ps
module irq_host_model (
	// clock
	input wire logic clk,
	// interrupt pin as driven by the device
	input wire logic pin_out,
	input wire logic pin_oe,
	// wire level seen by the host and count of level changes
	output logic pin_wire,
	output int unsigned changes
);
	logic prev;
	// external pull-up holds the wire high whenever the device lets go of it
	assign pin_wire = pin_oe ? pin_out : 1'b1;
	// one process owns both the previous level and the change count so each has a single driver
	initial begin
		prev = 1'b1;
		changes = 0;
		forever begin
			@(posedge clk);
			prev <= pin_wire;
			if (prev !== pin_wire) begin
				changes <= changes + 1;
			end
		end
	end
endmodule

// >>> dv/interrupt_request_controller_test.sv
// self-checking testbench of the interrupt request controller
`timescale 1ns/1ps
module interrupt_request_controller_test;
	import irq_pkg::*;
	logic clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid;
	logic [5:0] awaddr, araddr, evb;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, resp;
	logic [6:0] ev;
	logic [7:0] errb, rd, ea, eb, m, c, bv;
	logic pin_out, pin_oe, irq_level, pin_wire, grp;
	int unsigned changes;
	int fails, n_compared, k;
	interrupt_request_controller dut (.CORE_CLK(clk), .RSTN(rst_n),
		.AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb),
		.WVALID(wvalid), .WREADY(wready), .BRESP(bresp), .BVALID(bvalid), .BREADY(bready),
		.ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata), .RRESP(rresp),
		.RVALID(rvalid), .RREADY(rready), .HIGH_ALERT(ev[6]), .LOW_ALERT(ev[5]), .CMD_DONE(ev[4]),
		.TX_DONE(ev[3]), .RX_DONE(ev[2]), .FRAME_START(ev[0]), .CARD_DETECT(evb[5]),
		.TIMER_UNDERFLOW(evb[4:0]), .ERROR_BITS(errb), .IRQ_PIN_OUT(pin_out), .IRQ_PIN_OE(pin_oe),
		.IRQ_LEVEL(irq_level));
	irq_host_model host (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe), .pin_wire(pin_wire),
		.changes(changes));
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		n_compared++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] %0t %0s: saw %h expected %h", $time, what, seen, exp);
		end
	endtask
	task automatic test_done;
		$display("compared %0d, mismatches %0d, pin changes %0d", n_compared, fails, changes);
		if (fails == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// bus tasks wait for the answer however long it takes; only the watchdog ends a hang
	task automatic axw(input logic [5:0] a, input logic [7:0] d, output logic [1:0] r);
		@(posedge clk);
		awaddr <= a;
		wdata <= {24'h000000, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
	endtask
	task automatic axr(input logic [5:0] a, output logic [7:0] d, output logic [1:0] r);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			if (arvalid && arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		d = rdata[7:0];
		r = rresp;
		rready <= 1'b0;
	endtask
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		axw(a, d, resp);
		chk(resp, RESP_OKAY, "write response");
	endtask
	task automatic rchk(input logic [5:0] a, input logic [7:0] e);
		axr(a, rd, resp);
		chk({resp, rd}, {RESP_OKAY, e}, "register read");
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic pulse(input logic [6:0] a, input logic [5:0] b);
		@(posedge clk);
		ev <= a;
		evb <= b;
		@(posedge clk);
		ev <= 7'h00;
		evb <= 6'h00;
	endtask
	// expected pin drive {out, oe} from global request and the two enable registers
	function automatic logic [1:0] exp_pin(input logic g, input logic [7:0] a, input logic [7:0] b);
		logic lvl;
		lvl = (g & b[6]) ^ a[7];
		return b[7] ? {lvl, 1'b1} : {1'b0, ~lvl};
	endfunction
	task automatic pchk(input logic g, input logic [7:0] a, input logic [7:0] b);
		logic [1:0] e;
		e = exp_pin(g, a, b);
		chk({pin_out, pin_oe}, e, "pin drive");
		chk(pin_wire, e[0] ? e[1] : 1'b1, "pin wire");
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		fails++;
		$display("[ERR] %0t watchdog expired", $time);
		test_done;
	end
	initial begin
		rst_n = 1'b0;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		awaddr = 6'h00;
		araddr = 6'h00;
		wdata = 32'h00000000;
		wstrb = 4'hF;
		ev = 7'h00;
		evb = 6'h00;
		errb = 8'h00;
		fails = 0;
		n_compared = 0;
		void'($urandom(59));
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		cyc(2);
		pchk(1'b0, 8'h00, 8'h00);
		rchk(6'h20, 8'h00);
		rchk(6'h24, 8'h00);
		$display("test reset done");
		for (k = 0; k < 4; k++) begin
			ea = 8'($urandom);
			eb = 8'($urandom);
			wr(6'h20, ea);
			wr(6'h24, eb);
			rchk(6'h20, ea);
			rchk(6'h24, eb);
		end
		wr(6'h20, 8'h00);
		wr(6'h24, 8'h00);
		m = 8'h00;
		for (k = 0; k < 8; k++) begin
			c = 8'($urandom) & 8'h3F;
			wr(6'h1C, k[0] ? (8'h80 | c) : c);
			m = k[0] ? (m | c) : (m & ~c);
			rchk(6'h1C, m);
		end
		wr(6'h1C, 8'h3F);
		wr(6'h18, 8'hFF);
		rchk(6'h18, 8'h7F);
		wr(6'h18, 8'h7F);
		rchk(6'h18, 8'h00);
		$display("test set and clear done");
		for (k = 0; k < 7; k++) begin
			if (k != 1) begin
				bv = 8'(1 << k);
				pulse(bv[6:0], 6'h00);
				cyc(3);
				wr(6'h18, 8'h7F & ~bv);
				rchk(6'h18, bv);
				wr(6'h18, bv);
				rchk(6'h18, 8'h00);
			end
		end
		for (k = 0; k < 6; k++) begin
			bv = 8'(1 << k);
			pulse(7'h00, bv[5:0]);
			rchk(6'h1C, bv);
			wr(6'h1C, bv);
		end
		for (k = 0; k < 8; k++) begin
			errb <= 8'(1 << k);
			cyc(2);
			rchk(6'h28, 8'(1 << k));
			errb <= 8'h00;
			cyc(2);
			rchk(6'h18, ERR_TRIGGER_MASK[k] ? 8'h02 : 8'h00);
			wr(6'h18, 8'h02);
		end
		wr(6'h28, 8'hFF);
		rchk(6'h28, 8'h00);
		$display("test request events done");
		for (k = 0; k < 13; k++) begin
			grp = (k >= 7);
			bv = grp ? 8'(1 << (k - 7)) : 8'(1 << k);
			wr(grp ? 6'h1C : 6'h18, grp ? 8'h3F : 8'h7F);
			wr(grp ? 6'h1C : 6'h18, 8'h80 | bv);
			wr(grp ? 6'h24 : 6'h20, ~bv & (grp ? 8'h3F : 8'h7F));
			cyc(3);
			rchk(6'h1C, grp ? bv : 8'h00);
			wr(grp ? 6'h24 : 6'h20, bv);
			cyc(3);
			rchk(6'h1C, (grp ? bv : 8'h00) | 8'h40);
			if (k != 12) wr(grp ? 6'h24 : 6'h20, 8'h00);
		end
		cyc(3);
		pchk(1'b1, 8'h00, 8'h20);
		for (k = 0; k < 4; k++) begin
			ea = k[0] ? 8'h80 : 8'h00;
			eb = k[1] ? 8'hE0 : 8'h60;
			wr(6'h20, ea);
			wr(6'h24, eb);
			cyc(4);
			pchk(1'b1, ea, eb);
		end
		// inverted push-pull pin with the pin gate off idles high
		wr(6'h20, 8'h80);
		wr(6'h24, 8'hA0);
		cyc(4);
		pchk(1'b1, 8'h80, 8'hA0);
		$display("test global request and pin done");
		wr(6'h20, 8'h00);
		wr(6'h30, 8'h07);
		wr(6'h34, 8'h01);
		cyc(3);
		chk(irq_level, 1'b0, "no new event");
		wr(6'h24, 8'h40);
		wr(6'h24, 8'h60);
		cyc(4);
		chk(irq_level, 1'b1, "event raised");
		rchk(6'h30, 8'h01);
		wr(6'h34, 8'h00);
		cyc(3);
		chk(irq_level, 1'b0, "event masked");
		wr(6'h34, 8'h01);
		cyc(3);
		chk(irq_level, 1'b1, "event unmasked");
		wr(6'h30, 8'h01);
		cyc(3);
		chk(irq_level, 1'b0, "event cleared");
		// a write without byte lane 0 is answered but leaves the register alone
		wstrb <= 4'h0;
		wr(6'h34, 8'h00);
		wstrb <= 4'hF;
		rchk(6'h34, 8'h01);
		axw(6'h3C, 8'h5A, resp);
		chk(resp, RESP_SLVERR, "unmapped write");
		axr(6'h3C, rd, resp);
		chk({resp, rd}, {RESP_SLVERR, 8'h00}, "unmapped read");
		$display("test event line and decode done");
		test_done;
	end
endmodule
